/* File: ntbrp_bank.sv */
// Bridge reset and protection register bank for one side of the bridge.
// Assumes byte-wide configuration accesses on one clock, far side reset
// levels from logic on the same clock, and an asynchronous bridge reset pin.
`timescale 1ns/10ps
module ntbrp_bank #(
    parameter logic INTERNAL_SIDE = 1'b1  // One on the internal side
) (
    // Clock and reset
    input  wire logic                 clock,
    input  wire logic                 nrst,
    // Side resets and mode
    input  wire logic                 int_hot_rst,
    input  wire logic                 ntb_mode,
    input  wire logic                 bridge_reset_in_n,
    // Far side reset indications and ready request
    input  wire logic                 far_fund_rst,
    input  wire logic                 far_hot_rst,
    input  wire logic                 peer_set_ready,
    // Configuration access port
    input  wire logic                 cfg_valid,
    input  wire logic                 cfg_write,
    input  wire logic                 cfg_far,
    input  wire logic [11:0]          cfg_addr,
    input  wire logic [7:0]           cfg_wdata,
    output logic                      cfg_ack,
    output logic [7:0]                cfg_rdata,
    // Control outputs
    output logic [1:0]                far_side_mode,
    output logic                      far_cfg_retry,
    output logic                      far_drop,
    output logic                      peer_ready_req,
    output logic                      device_reset_req
);
    import ntbrp_pkg::*;

    // Whole state of the bank
    typedef struct packed {
        logic [3:0][7:0] hdr;        // Capability header bytes
        logic [1:0]      mode;       // far_side_mode
        logic            prot;       // cfg_write_protect
        logic            reset_action_enable;       // reset_action_enable
        logic            ra;         // reset_action_select
        logic            ext_reset_propagate;       // ext_reset_propagate
        logic            frd;        // far_side_fund_reset_seen
        logic            fund_prev;  // Far fundamental reset, last cycle
        logic            any_prev;   // Any far reset, last cycle
        logic            ack;        // Access answer
        logic [7:0]      rdata;      // Read data
        logic            retry;      // Retry far config requests
        logic            drop;       // Drop other far traffic
        logic            peer_rdy;   // Ready request to far side
        logic            dev_rst;    // Whole device reset
    } ntbrp_bank_s;

    ntbrp_bank_s st_q;      // Registered state
    ntbrp_bank_s st_d;      // Next state
    logic        pin_n_s;   // Synchronised bridge reset pin
    logic        in_cap;    // Address inside capability structure
    logic        in_hdr;    // Address inside capability header
    logic        blocked;   // Protected far access
    logic        fund_edge; // New far fundamental reset
    logic        any_edge;  // New far reset of either kind
    logic [1:0]  mode_dft;  // Mode after internal reset

    // Bridge reset pin into the core domain
    ntbrp_sync #(
        .RST_VAL (1'b1)
    ) u_pin_sync (
        .clock    (clock),
        .nrst     (nrst),
        .pin_in   (bridge_reset_in_n),
        .sync_out (pin_n_s)
    );

    // Address range check
    function automatic logic ntbrp_in_range(input logic [11:0] a, input logic [11:0] lo,
                                            input logic [11:0] hi);
        ntbrp_in_range = (a >= lo) && (a <= hi);
    endfunction

    // Readback of bridge_control, trigger bit always zero
    function automatic logic [7:0] ntbrp_ctl_read(input ntbrp_bank_s s);
        logic [7:0] v;
        v = 8'h00;
        v[NTBRP_CTL_MODE_LSB +: 2] = s.mode;
        v[NTBRP_CTL_PROT] = s.prot;
        v[NTBRP_CTL_RESET_ACTION_ENABLE] = s.reset_action_enable;
        v[NTBRP_CTL_RA]   = s.ra;
        v[NTBRP_CTL_EXT_RESET_PROPAGATE] = s.ext_reset_propagate;
        ntbrp_ctl_read = v;
    endfunction

    // Access classification and far reset edges
    always_comb begin
        in_cap    = ntbrp_in_range(cfg_addr, NTBRP_CAP_HDR_OFS, NTBRP_CAP_LAST_OFS);
        in_hdr    = ntbrp_in_range(cfg_addr, NTBRP_CAP_HDR_OFS, NTBRP_HDR_LAST_OFS);
        blocked   = st_q.prot && cfg_far && in_cap;
        fund_edge = far_fund_rst && !st_q.fund_prev;
        any_edge  = (far_fund_rst || far_hot_rst) && !st_q.any_prev;
        mode_dft  = INTERNAL_SIDE ? NTBRP_MODE_ENABLED : NTBRP_MODE_NOT_READY;
    end

    // Next state
    always_comb begin
        st_d           = st_q;
        st_d.ack       = cfg_valid;
        st_d.peer_rdy  = 1'b0;
        st_d.dev_rst   = 1'b0;
        st_d.fund_prev = far_fund_rst;
        st_d.any_prev  = far_fund_rst || far_hot_rst;
        // Register writes
        if (cfg_valid && cfg_write) begin
            if (blocked) begin
                st_d.hdr = st_q.hdr;
            end else if (in_hdr) begin
                // Header bytes, writable for test
                st_d.hdr[cfg_addr[1:0]] = cfg_wdata;
            end else if (cfg_addr == NTBRP_CTRL_OFS) begin
                st_d.mode = cfg_wdata[NTBRP_CTL_MODE_LSB +: 2];
                st_d.prot = cfg_wdata[NTBRP_CTL_PROT];
                st_d.ext_reset_propagate = cfg_wdata[NTBRP_CTL_EXT_RESET_PROPAGATE];
                if (INTERNAL_SIDE) begin
                    st_d.reset_action_enable = cfg_wdata[NTBRP_CTL_RESET_ACTION_ENABLE];
                    st_d.ra   = cfg_wdata[NTBRP_CTL_RA];
                end
                st_d.dev_rst = cfg_wdata[NTBRP_CTL_RST];
            end else if (cfg_addr == NTBRP_STAT_OFS) begin
                // Write one clears the flag
                if (cfg_wdata[NTBRP_STS_FRD]) begin
                    st_d.frd = 1'b0;
                end
            end
        end
        // Register reads
        st_d.rdata = 8'h00;
        if (cfg_valid && !cfg_write) begin
            if (in_hdr) begin
                st_d.rdata = st_q.hdr[cfg_addr[1:0]];
            end else if (blocked) begin
                st_d.rdata = 8'h00;
            end else if (cfg_addr == NTBRP_CTRL_OFS) begin
                st_d.rdata = ntbrp_ctl_read(st_q);
            end else if (cfg_addr == NTBRP_STAT_OFS) begin
                st_d.rdata[NTBRP_STS_FRD] = st_q.frd;
            end
        end
        // Far side asks us to become ready
        if (peer_set_ready) begin
            st_d.mode = NTBRP_MODE_ENABLED;
        end
        if (any_edge && st_q.reset_action_enable && INTERNAL_SIDE) begin
            if (st_q.ra == NTBRP_RA_THIS_NOT_READY) begin
                st_d.peer_rdy = 1'b1;
            end else begin
                st_d.mode = NTBRP_MODE_NOT_READY;
            end
        end
        if (fund_edge) begin
            st_d.frd = 1'b1;
        end
        if (st_q.ext_reset_propagate && ntb_mode && !pin_n_s) begin
            st_d.dev_rst = 1'b1;
        end
        // Internal hot reset restores non-sticky fields
        if (int_hot_rst) begin
            st_d.mode = mode_dft;
            st_d.hdr  = {NTBRP_HDR3_RST, NTBRP_HDR2_RST, NTBRP_HDR1_RST, NTBRP_HDR0_RST};
        end
        st_d.retry = (st_d.mode == NTBRP_MODE_NOT_READY);
        st_d.drop  = (st_d.mode != NTBRP_MODE_ENABLED);
    end

    // State register; only internal fundamental reset clears it
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st_q           <= '0;
            st_q.hdr       <= {NTBRP_HDR3_RST, NTBRP_HDR2_RST, NTBRP_HDR1_RST, NTBRP_HDR0_RST};
            st_q.mode      <= INTERNAL_SIDE ? NTBRP_MODE_ENABLED : NTBRP_MODE_NOT_READY;
            st_q.prot      <= NTBRP_STICKY_RST;
            st_q.reset_action_enable      <= NTBRP_STICKY_RST;
            st_q.ra        <= NTBRP_STICKY_RST;
            st_q.ext_reset_propagate      <= NTBRP_STICKY_RST;
            st_q.retry     <= !INTERNAL_SIDE;
            st_q.drop      <= !INTERNAL_SIDE;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state register
    assign cfg_ack          = st_q.ack;
    assign cfg_rdata        = st_q.rdata;
    assign far_side_mode    = st_q.mode;
    assign far_cfg_retry    = st_q.retry;
    assign far_drop         = st_q.drop;
    assign peer_ready_req   = st_q.peer_rdy;
    assign device_reset_req = st_q.dev_rst;

    // Assertions share the core clock and reset
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    // Protected far write to control
    sequence s_far_ctl_write;
        cfg_valid && cfg_write && cfg_far && st_q.prot && (cfg_addr == NTBRP_CTRL_OFS)
            && !peer_set_ready && !int_hot_rst && !any_edge;
    endsequence

    a_prot_write_held: assert property (s_far_ctl_write |=> $stable(ntbrp_ctl_read(st_q)) && cfg_ack)
        else $error("protected far write changed control");

    a_prot_read_zero: assert property (cfg_valid && !cfg_write && blocked && !in_hdr
        |=> cfg_ack && (cfg_rdata == 8'h00))
        else $error("protected read not zero");

    a_hot_keeps_sticky: assert property (int_hot_rst && !(cfg_valid && cfg_write)
        |=> $stable(st_q.prot) && $stable(st_q.ext_reset_propagate) && $stable(st_q.reset_action_enable))
        else $error("sticky bit lost at hot reset");

    a_ext_side_zero: assert property (!INTERNAL_SIDE |-> !st_q.reset_action_enable && !st_q.ra)
        else $error("action bits set on external side");

    a_action_ready: assert property (any_edge && st_q.reset_action_enable && !st_q.ra && INTERNAL_SIDE
        |=> peer_ready_req ##1 !peer_ready_req)
        else $error("ready request not a single pulse");

    a_action_notready: assert property (any_edge && st_q.reset_action_enable && st_q.ra && INTERNAL_SIDE
        && !int_hot_rst |=> (far_side_mode == NTBRP_MODE_NOT_READY) && far_cfg_retry && far_drop)
        else $error("own mode not made not ready");

    a_pin_propagate: assert property (st_q.ext_reset_propagate && ntb_mode && !pin_n_s |=> device_reset_req)
        else $error("bridge reset not propagated");

    a_rst_reads_zero: assert property (cfg_valid && !cfg_write && (cfg_addr == NTBRP_CTRL_OFS)
        |=> cfg_ack && !cfg_rdata[NTBRP_CTL_RST])
        else $error("trigger bit read back as one");

    a_flag_set_wins: assert property (fund_edge |=> st_q.frd)
        else $error("fundamental reset flag not set");

    a_mode_retry: assert property (far_side_mode == NTBRP_MODE_NOT_READY |-> far_cfg_retry && far_drop)
        else $error("not ready mode without retry");

    a_action_once: assert property (peer_ready_req && (far_fund_rst || far_hot_rst)
        |=> !peer_ready_req)
        else $error("reset action repeated");

    // Every access answered exactly one cycle later
    a_ack_one_cycle: assert property (cfg_valid |=> cfg_ack)
        else $error("access not answered in one cycle");

    // Unprotected write of one to the trigger bit
    sequence s_trigger_write;
        cfg_valid && cfg_write && !blocked && (cfg_addr == NTBRP_CTRL_OFS)
            && cfg_wdata[NTBRP_CTL_RST];
    endsequence

    a_trigger_pulse: assert property (s_trigger_write |=> device_reset_req)
        else $error("trigger write did not reset device");

    // Unprotected one written to the flag with no new far fundamental reset
    sequence s_flag_clear;
        cfg_valid && cfg_write && !blocked && (cfg_addr == NTBRP_STAT_OFS)
            && cfg_wdata[NTBRP_STS_FRD] && !fund_edge;
    endsequence

    a_flag_cleared: assert property (s_flag_clear |=> !st_q.frd)
        else $error("fundamental reset flag not cleared");

    // Internal hot reset puts the mode back to its default
    a_hot_mode_dft: assert property (int_hot_rst |=> far_side_mode == mode_dft)
        else $error("mode not restored at hot reset");

    // Device reset only from a write or the propagated pin
    a_reset_cause: assert property (!(cfg_valid && cfg_write) && !(st_q.ext_reset_propagate && ntb_mode && !pin_n_s)
        |=> !device_reset_req)
        else $error("device reset without a cause");
endmodule

/* File: ntbrp_pkg.sv */
// Shared constants for the bridge reset and protection register bank.
// Assumes byte-wide configuration accesses at the bank's printed offsets.
package ntbrp_pkg;

    // Byte offsets of the bank
    localparam logic [11:0] NTBRP_CAP_HDR_OFS  = 12'h074;  // Capability header, four bytes
    localparam logic [11:0] NTBRP_CTRL_OFS     = 12'h078;  // bridge_control
    localparam logic [11:0] NTBRP_STAT_OFS     = 12'h079;  // bridge_status
    localparam logic [11:0] NTBRP_CAP_LAST_OFS = 12'h0b3;  // Last byte of the capability structure
    localparam logic [11:0] NTBRP_HDR_LAST_OFS = 12'h077;  // Last byte of the capability header

    // Capability header reset values, byte 0 upward
    localparam logic [7:0] NTBRP_HDR0_RST = 8'h09;  // Vendor specific id
    localparam logic [7:0] NTBRP_HDR1_RST = 8'hb4;  // Next pointer
    localparam logic [7:0] NTBRP_HDR2_RST = 8'h40;  // Capability length
    localparam logic [7:0] NTBRP_HDR3_RST = 8'h01;  // Capability kind

    // bridge_control field positions
    localparam int NTBRP_CTL_MODE_LSB = 0;  // far_side_mode, two bits
    localparam int NTBRP_CTL_PROT     = 2;  // cfg_write_protect
    localparam int NTBRP_CTL_RESET_ACTION_ENABLE     = 3;  // reset_action_enable
    localparam int NTBRP_CTL_RA       = 4;  // reset_action_select
    localparam int NTBRP_CTL_EXT_RESET_PROPAGATE     = 5;  // ext_reset_propagate
    localparam int NTBRP_CTL_RST      = 7;  // Device reset trigger
    // bridge_status field positions
    localparam int NTBRP_STS_FRD      = 0;  // far_side_fund_reset_seen

    // Far side mode encodings
    localparam logic [1:0] NTBRP_MODE_NOT_READY = 2'h0;
    localparam logic [1:0] NTBRP_MODE_ENABLED   = 2'h1;
    localparam logic [1:0] NTBRP_MODE_DISABLED  = 2'h2;

    // Reset action encodings
    localparam logic NTBRP_RA_THIS_NOT_READY = 1'b0;
    localparam logic NTBRP_RA_FAR_NOT_READY  = 1'b1;

    // Sticky control bits after reset
    localparam logic NTBRP_STICKY_RST = 1'b0;
    // Synchroniser depth
    localparam int NTBRP_SYNC_STAGES = 2;

endpackage

/* File: ntbrp_sync.sv */
// Two-flop synchroniser for pins entering the core clock domain.
// Assumes the input is a level held for at least two core clocks.
`timescale 1ns/10ps
module ntbrp_sync #(
    parameter logic RST_VAL = 1'b1
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic nrst,
    // Pin side
    input  wire logic pin_in,
    // Core side
    output logic      sync_out
);
    import ntbrp_pkg::*;

    // Both stages of the chain
    typedef struct packed {
        logic meta;  // First stage, read only by the second
        logic sync;  // Second stage
    } ntbrp_sync_s;

    ntbrp_sync_s st_q;  // Registered state
    ntbrp_sync_s st_d;  // Next state

    // Shift the pin through the chain
    always_comb begin
        st_d      = st_q;
        st_d.meta = pin_in;
        st_d.sync = st_q.meta;
    end

    // State register
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st_q <= '{meta: RST_VAL, sync: RST_VAL};
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_out = st_q.sync;
endmodule

/* File: ntbrp_far_model.sv */
// Far side model: opposite-side reset levels and ready requests.
// Assumes the bench calls its tasks from the core clock domain.
`timescale 1ns/10ps
module ntbrp_far_model (
    // Clock
    input  wire logic clock,
    // Toward the bank
    output logic      far_fund_rst,
    output logic      far_hot_rst,
    output logic      peer_set_ready
);
    // Quiet from time zero
    initial begin
        far_fund_rst   = 1'b0;
        far_hot_rst    = 1'b0;
        peer_set_ready = 1'b0;
    end
    // Raise or drop one far reset level after an edge
    task automatic set_rst(input logic hot, input logic lvl);
        @(posedge clock);
        if (hot)
            far_hot_rst <= lvl;
        else
            far_fund_rst <= lvl;
    endtask
    // One-cycle request from the far side to make us ready
    task automatic peer_ready();
        @(posedge clock);
        peer_set_ready <= 1'b1;
        @(posedge clock);
        peer_set_ready <= 1'b0;
    endtask
endmodule

/* File: ntbrp_bank_tb.sv */
// Bench for the bridge reset and protection bank, both sides at once.
// Assumes byte accesses answered one cycle after they are taken.
`timescale 1ns/10ps
module ntbrp_bank_tb;
    import ntbrp_pkg::*;
    localparam logic [11:0] CT = NTBRP_CTRL_OFS;
    localparam logic [11:0] ST = NTBRP_STAT_OFS;
    localparam logic [11:0] HD = NTBRP_CAP_HDR_OFS;
    logic clock = 1'b0, nrst = 1'b0, int_hot_rst = 1'b0, ntb_mode = 1'b0;
    logic bridge_reset_in_n = 1'b1, cfg_valid = 1'b0, cfg_write = 1'b0, cfg_far = 1'b0;
    logic [11:0] cfg_addr = 12'h000;
    logic [7:0]  cfg_wdata = 8'h00, cfg_rdata, rd_x, d;
    logic cfg_ack, ack_x, far_fund_rst, far_hot_rst, peer_set_ready;
    logic [1:0] far_side_mode;
    logic far_cfg_retry, far_drop, peer_ready_req, device_reset_req;
    logic [7:0] hdr [4] = '{NTBRP_HDR0_RST, NTBRP_HDR1_RST, NTBRP_HDR2_RST, NTBRP_HDR3_RST};
    integer seed = 75635, error_cnt = 0, comparisons = 0, cnt;
    // Core clock, 25 ns
    always #12.5 clock = ~clock;
    // Internal side under test
    ntbrp_bank #(.INTERNAL_SIDE(1'b1)) u_ntbrp_bank (.clock(clock), .nrst(nrst), .int_hot_rst(int_hot_rst),
        .ntb_mode(ntb_mode), .bridge_reset_in_n(bridge_reset_in_n), .far_fund_rst(far_fund_rst),
        .far_hot_rst(far_hot_rst), .peer_set_ready(peer_set_ready), .cfg_valid(cfg_valid),
        .cfg_write(cfg_write), .cfg_far(cfg_far), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
        .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .far_side_mode(far_side_mode),
        .far_cfg_retry(far_cfg_retry), .far_drop(far_drop), .peer_ready_req(peer_ready_req),
        .device_reset_req(device_reset_req));
    // External side sharing all stimulus
    ntbrp_bank #(.INTERNAL_SIDE(1'b0)) u_ntbrp_bank_x (.clock(clock), .nrst(nrst), .int_hot_rst(int_hot_rst),
        .ntb_mode(ntb_mode), .bridge_reset_in_n(bridge_reset_in_n), .far_fund_rst(far_fund_rst),
        .far_hot_rst(far_hot_rst), .peer_set_ready(peer_set_ready), .cfg_valid(cfg_valid),
        .cfg_write(cfg_write), .cfg_far(cfg_far), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
        .cfg_ack(ack_x), .cfg_rdata(rd_x), .far_side_mode(), .far_cfg_retry(), .far_drop(),
        .peer_ready_req(), .device_reset_req());
    // Opposite side
    ntbrp_far_model u_ntbrp_far_model (.clock(clock), .far_fund_rst(far_fund_rst),
        .far_hot_rst(far_hot_rst), .peer_set_ready(peer_set_ready));
    // Byte compare
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask
    // One access; reads compare both sides
    task automatic acc(input logic w, f, input logic [11:0] a, input logic [7:0] wd, e, ex);
        @(posedge clock);
        cfg_valid <= 1'b1;
        cfg_write <= w;
        cfg_far   <= f;
        cfg_addr  <= a;
        cfg_wdata <= wd;
        @(posedge clock);
        cfg_valid <= 1'b0;
        #1;
        chk("ack", 8'h03, {6'h0, cfg_ack, ack_x});
        if (!w) begin
            chk("rdata", e, cfg_rdata);
            chk("rdata_x", ex, rd_x);
        end
    endtask
    // Control byte as read back on one side
    function automatic logic [7:0] ctl_exp(input logic ext, input logic [7:0] v);
        ctl_exp = v & (ext ? 8'h27 : 8'h3f);
    endfunction
    // Settled state outputs one cycle on
    task automatic outs(input logic [7:0] e);
        @(posedge clock);
        #1;
        chk("outs", e, {2'h0, far_side_mode, far_cfg_retry, far_drop, peer_ready_req, device_reset_req});
    endtask
    // Verdict
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (5000) @(posedge clock);
        error_cnt++;
        end_of_test();
    end
    // Main sequence
    initial begin
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        for (int i = 0; i < 4; i++)
            acc(0, 0, HD + 12'(i), 8'h00, hdr[i], hdr[i]);
        acc(0, 0, CT, 8'h00, 8'h01, 8'h00);
        acc(0, 0, ST, 8'h00, 8'h00, 8'h00);
        $display("test reset_values done");
        acc(1, 0, CT, 8'h81, 8'h00, 8'h00);
        chk("dev_rst", 8'h01, {7'h0, device_reset_req});
        outs(8'h10);
        acc(0, 0, CT, 8'h00, 8'h01, 8'h01);
        $display("test reset_trigger done");
        for (int i = 0; i < 6; i++) begin
            d = (8'($random(seed)) & 8'hfc) | 8'h01;
            acc(1, 0, CT, d, 8'h00, 8'h00);
            acc(0, 0, CT, 8'h00, ctl_exp(1'b0, d), ctl_exp(1'b1, d));
        end
        $display("test side_fields done");
        acc(1, 0, CT, 8'h3d, 8'h00, 8'h00);
        acc(1, 1, CT, 8'($random(seed)), 8'h00, 8'h00);
        acc(1, 1, HD, 8'h55, 8'h00, 8'h00);
        acc(0, 0, CT, 8'h00, 8'h3d, 8'h25);
        acc(0, 1, CT, 8'h00, 8'h00, 8'h00);
        for (int i = 0; i < 4; i++)
            acc(0, 1, HD + 12'(i), 8'h00, hdr[i], hdr[i]);
        $display("test protection done");
        u_ntbrp_far_model.set_rst(1'b0, 1'b1);
        outs(8'h0c);
        acc(0, 0, ST, 8'h00, 8'h01, 8'h01);
        u_ntbrp_far_model.peer_ready();
        #1;
        repeat (4) outs(8'h10);
        u_ntbrp_far_model.set_rst(1'b0, 1'b0);
        acc(1, 0, ST, 8'h01, 8'h00, 8'h00);
        acc(0, 0, ST, 8'h00, 8'h00, 8'h00);
        acc(1, 0, CT, 8'h2d, 8'h00, 8'h00);
        u_ntbrp_far_model.set_rst(1'b1, 1'b1);
        outs(8'h12);
        outs(8'h10);
        u_ntbrp_far_model.set_rst(1'b1, 1'b0);
        acc(0, 0, ST, 8'h00, 8'h00, 8'h00);
        acc(1, 0, CT, 8'h21, 8'h00, 8'h00);
        u_ntbrp_far_model.set_rst(1'b0, 1'b1);
        outs(8'h10);
        u_ntbrp_far_model.set_rst(1'b0, 1'b0);
        acc(0, 1, CT, 8'h00, 8'h21, 8'h21);
        $display("test reset_action done");
        @(posedge clock);
        bridge_reset_in_n <= 1'b0;
        cnt = 0;
        repeat (6) begin
            @(posedge clock);
            #1;
            cnt += device_reset_req;
        end
        chk("pin_no_ntb", 8'h00, 8'(cnt));
        @(posedge clock);
        ntb_mode <= 1'b1;
        repeat (3) @(posedge clock);
        #1;
        chk("pin_prop", 8'h01, {7'h0, device_reset_req});
        @(posedge clock);
        bridge_reset_in_n <= 1'b1;
        repeat (5) @(posedge clock);
        #1;
        chk("pin_free", 8'h00, {7'h0, device_reset_req});
        $display("test pin_propagate done");
        acc(1, 0, CT, 8'h26, 8'h00, 8'h00);
        outs(8'h24);
        @(posedge clock);
        int_hot_rst <= 1'b1;
        @(posedge clock);
        int_hot_rst <= 1'b0;
        acc(0, 0, CT, 8'h00, 8'h25, 8'h24);
        @(posedge clock);
        nrst <= 1'b0;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        acc(0, 0, CT, 8'h00, 8'h01, 8'h00);
        $display("test sticky_bits done");
        end_of_test();
    end
endmodule
